//--- eis_pkg.sv
// Purpose: shared constants and types for the error interrupt status block
// Assumes: one 32-bit status register plus a view select register, reached over a plain strobe port
// Notes:   bit positions are given in pci numbering (bit 31 is msb)
package eis_pkg;

  localparam int unsigned EIS_ADDR_W = 4;
  localparam int unsigned EIS_DATA_W = 32;

  // register index map (byte address = index * 4)
  localparam logic [EIS_ADDR_W-1:0] EIS_ERR_STATUS_IDX  = 4'h0;
  localparam logic [EIS_ADDR_W-1:0] EIS_VIEW_SELECT_IDX = 4'h1;

  localparam logic [31:0] EIS_ERR_STATUS_RST = 32'h0000_0000;
  localparam logic        EIS_VIEW_RST       = 1'h0;
  localparam logic        EIS_DUAL_PCI       = 1'h1;

  // field positions, pci numbering
  localparam int unsigned EIS_B_SUMMARY        = 31;
  localparam int unsigned EIS_B_HB_RETRY_P1    = 27;
  localparam int unsigned EIS_B_HB_RETRY_P2    = 26;
  localparam int unsigned EIS_B_HB_RETRY_LOOP  = 25;
  localparam int unsigned EIS_B_HB_XERR_P1     = 23;
  localparam int unsigned EIS_B_HB_XERR_P2     = 22;
  localparam int unsigned EIS_B_HB_XERR_LOOP   = 21;
  localparam int unsigned EIS_B_HB_APAR        = 20;
  localparam int unsigned EIS_B_HB_DPAR_P1     = 19;
  localparam int unsigned EIS_B_HB_DPAR_P2     = 18;
  localparam int unsigned EIS_B_HB_DPAR_LOOP   = 17;
  localparam int unsigned EIS_B_P2_ERR_P1      = 15;
  localparam int unsigned EIS_B_P2_ERR_HOST    = 14;
  localparam int unsigned EIS_B_P2_ERR_LOOP    = 13;
  localparam int unsigned EIS_B_P2_APAR        = 12;
  localparam int unsigned EIS_B_P2_RETRY_P1    = 11;
  localparam int unsigned EIS_B_P2_RETRY_HOST  = 10;
  localparam int unsigned EIS_B_P2_RETRY_LOOP  = 9;
  localparam int unsigned EIS_B_P1_ERR_P2      = 7;
  localparam int unsigned EIS_B_P1_ERR_HOST    = 6;
  localparam int unsigned EIS_B_P1_ERR_LOOP    = 5;
  localparam int unsigned EIS_B_P1_APAR        = 4;
  localparam int unsigned EIS_B_P1_RETRY_P2    = 3;
  localparam int unsigned EIS_B_P1_RETRY_HOST  = 2;
  localparam int unsigned EIS_B_P1_RETRY_LOOP  = 1;

  // bits that depend on the second pci bus
  localparam logic [31:0] EIS_P2_ONLY_MASK = 32'h0444_FE88;
  // all sticky event bits
  localparam logic [31:0] EIS_EVENT_MASK   = 32'h0EFE_FEFE;

  // one-cycle event pulses, grouped by the interface that saw them
  typedef struct packed {
    logic retry_limit_first_pci;
    logic retry_limit_second_pci;
    logic retry_limit_loop_dma;
    logic xfer_error_first_pci;
    logic xfer_error_second_pci;
    logic xfer_error_loop_dma;
    logic addr_parity_error;
    logic data_parity_first_pci;
    logic data_parity_second_pci;
    logic data_parity_loop_dma;
  } eis_host_evt_t;

  typedef struct packed {
    logic error_to_other;
    logic error_to_host;
    logic error_loop_dma;
    logic addr_parity_error;
    logic retry_from_other;
    logic retry_from_host;
    logic retry_loop_dma;
  } eis_pci_evt_t;

  typedef struct packed {
    logic [EIS_ADDR_W-1:0] addr;
    logic [EIS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } eis_bus_req_t;

endpackage

//--- eis_w1c_bit.sv
// Purpose: one sticky status bit, set by hardware, cleared by writing one
// Assumes: set and clear are one-cycle pulses in the clock domain
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/10ps
module eis_w1c_bit #(
  parameter logic ENABLE = 1'h1
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // control
  input  wire logic set_evt,
  input  wire logic clr_evt,
  // state
  output logic      flag_q
);

  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clr_evt) begin
      flag_d = 1'b0;
    end
    // a new event must not be lost to a concurrent clear
    if (set_evt && ENABLE) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

//--- eis_error_status.sv
// Purpose: error interrupt status register with write-one-to-clear fields
// Assumes: event inputs are synchronous one-cycle or level pulses
// Notes:   two views of the same word, pci order and host-bus (mirrored) order
//
// Functional notes
// [RQ1] summary bit 31 follows whether any primary status bit is set
// [RQ2] bit 27 sets on host bus retry limit toward first pci, w1c
// [RQ3] bit 26 sets on host bus retry limit toward second pci, w1c
// [RQ4] bit 25 sets on host bus retry limit during loop dma, w1c
// [RQ5] bit 23 sets on transfer error ack toward first pci, w1c
// [RQ6] bit 22 sets on transfer error ack toward second pci, w1c
// [RQ7] bit 21 sets on transfer error ack during loop dma, w1c
// [RQ8] bit 20 sets on host bus address parity error, held until w1c
// [RQ9] bit 19 sets on host bus data parity toward first pci, w1c
// [RQ10] bit 18 sets on host bus data parity toward second pci, w1c
// [RQ11] bit 17 sets on host bus data parity during loop dma, w1c
// [RQ12] bit 15 sets on second pci error toward first pci, w1c
// [RQ13] bit 14 sets on second pci error toward host bus, w1c
// [RQ14] bit 13 sets on second pci error during its loop dma, w1c
// [RQ15] bit 12 sets on second pci address parity error, w1c
// [RQ16] bits 11..9 set on second pci master retry overflow, each w1c
// [RQ17] bits 30..28, 24, 16, 8, 0 read zero and ignore writes
// [RQ18] bits 7..5 set on first pci errors by destination, each w1c
// [RQ19] bit 4 sets on first pci address parity error, w1c
// [RQ20] bits 3..1 set on first pci master retry overflow, each w1c
// [RQ21] reset clears all fields; writing zero leaves fields unchanged
// [RQ22] host-bus view bit n equals pci bit 31 minus n
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module eis_error_status #(
  parameter logic DUAL_PCI = eis_pkg::EIS_DUAL_PCI
) (
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            reset_n,
  // register port
  input  wire logic [eis_pkg::EIS_ADDR_W-1:0]  reg_addr,
  input  wire logic [eis_pkg::EIS_DATA_W-1:0]  reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [eis_pkg::EIS_DATA_W-1:0]  reg_rdata,
  // error events
  input  wire eis_pkg::eis_host_evt_t          host_evt,
  input  wire eis_pkg::eis_pci_evt_t           first_pci_evt,
  input  wire eis_pkg::eis_pci_evt_t           second_pci_evt,
  // primary status summary input
  input  wire logic                            primary_status_any,
  // status outputs
  output logic                                 primary_summary_flag,
  output logic      [31:0]                     error_status_word,
  output logic                                 error_any
);

  // mirror a word between pci and host-bus bit order
  function automatic logic [31:0] eis_mirror(input logic [31:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      r[i] = w[31-i];
    end
    return r;
  endfunction

  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] flag_vec;
  logic [31:0] status_word;
  logic [31:0] wr_pci;
  logic        wr_status;
  logic        wr_view;
  logic        view_host_q;
  logic        summary_q;
  logic [31:0] rdata_q;
  logic [31:0] status_out_q;
  logic        any_q;

  assign wr_status = reg_wr && (reg_addr == eis_pkg::EIS_ERR_STATUS_IDX);
  assign wr_view   = reg_wr && (reg_addr == eis_pkg::EIS_VIEW_SELECT_IDX);

  // writes arrive in whichever bit order the selected view uses
  assign wr_pci = view_host_q ? eis_mirror(reg_wdata) : reg_wdata; // RQ22

  // only ones clear, zeros leave fields unchanged
  assign clr_vec = wr_status ? (wr_pci & eis_pkg::EIS_EVENT_MASK) : 32'h0000_0000; // RQ21 RQ17

  // event routing to pci bit positions
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[eis_pkg::EIS_B_HB_RETRY_P1]   = host_evt.retry_limit_first_pci; // RQ2
    set_vec[eis_pkg::EIS_B_HB_RETRY_P2]   = host_evt.retry_limit_second_pci; // RQ3
    set_vec[eis_pkg::EIS_B_HB_RETRY_LOOP] = host_evt.retry_limit_loop_dma; // RQ4
    set_vec[eis_pkg::EIS_B_HB_XERR_P1]    = host_evt.xfer_error_first_pci; // RQ5
    set_vec[eis_pkg::EIS_B_HB_XERR_P2]    = host_evt.xfer_error_second_pci; // RQ6
    set_vec[eis_pkg::EIS_B_HB_XERR_LOOP]  = host_evt.xfer_error_loop_dma; // RQ7
    set_vec[eis_pkg::EIS_B_HB_APAR]       = host_evt.addr_parity_error; // RQ8
    set_vec[eis_pkg::EIS_B_HB_DPAR_P1]    = host_evt.data_parity_first_pci; // RQ9
    set_vec[eis_pkg::EIS_B_HB_DPAR_P2]    = host_evt.data_parity_second_pci; // RQ10
    set_vec[eis_pkg::EIS_B_HB_DPAR_LOOP]  = host_evt.data_parity_loop_dma; // RQ11
    set_vec[eis_pkg::EIS_B_P2_ERR_P1]     = second_pci_evt.error_to_other; // RQ12
    set_vec[eis_pkg::EIS_B_P2_ERR_HOST]   = second_pci_evt.error_to_host; // RQ13
    set_vec[eis_pkg::EIS_B_P2_ERR_LOOP]   = second_pci_evt.error_loop_dma; // RQ14
    set_vec[eis_pkg::EIS_B_P2_APAR]       = second_pci_evt.addr_parity_error; // RQ15
    set_vec[eis_pkg::EIS_B_P2_RETRY_P1]   = second_pci_evt.retry_from_other; // RQ16
    set_vec[eis_pkg::EIS_B_P2_RETRY_HOST] = second_pci_evt.retry_from_host; // RQ16
    set_vec[eis_pkg::EIS_B_P2_RETRY_LOOP] = second_pci_evt.retry_loop_dma; // RQ16
    set_vec[eis_pkg::EIS_B_P1_ERR_P2]     = first_pci_evt.error_to_other; // RQ18
    set_vec[eis_pkg::EIS_B_P1_ERR_HOST]   = first_pci_evt.error_to_host; // RQ18
    set_vec[eis_pkg::EIS_B_P1_ERR_LOOP]   = first_pci_evt.error_loop_dma; // RQ18
    set_vec[eis_pkg::EIS_B_P1_APAR]       = first_pci_evt.addr_parity_error; // RQ19
    set_vec[eis_pkg::EIS_B_P1_RETRY_P2]   = first_pci_evt.retry_from_other; // RQ20
    set_vec[eis_pkg::EIS_B_P1_RETRY_HOST] = first_pci_evt.retry_from_host; // RQ20
    set_vec[eis_pkg::EIS_B_P1_RETRY_LOOP] = first_pci_evt.retry_loop_dma; // RQ20
  end

  // one sticky cell per event bit; reserved and second-bus bits in a
  // single-bus build are tied off so they can never read one
  for (genvar g = 0; g < 32; g++) begin : g_bits
    if (eis_pkg::EIS_EVENT_MASK[g]) begin : g_evt
      eis_w1c_bit #(
        .ENABLE (DUAL_PCI || !eis_pkg::EIS_P2_ONLY_MASK[g])
      ) u_bit (
        .clock   (clock),
        .reset_n (reset_n),
        .set_evt (set_vec[g]),
        .clr_evt (clr_vec[g]),
        .flag_q  (flag_vec[g])
      );
    end else begin : g_rsvd
      assign flag_vec[g] = 1'b0; // RQ17
    end
  end

  // summary registered so the word and the flag output both come from flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      summary_q <= 1'b0; // RQ21
    end else begin
      summary_q <= primary_status_any; // RQ1
    end
  end

  always_comb begin
    status_word = flag_vec;
    status_word[eis_pkg::EIS_B_SUMMARY] = summary_q; // RQ1
  end

  // view select: 0 = pci bit order, 1 = host-bus bit order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      view_host_q <= eis_pkg::EIS_VIEW_RST;
    end else if (wr_view) begin
      view_host_q <= reg_wdata[0];
    end
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        eis_pkg::EIS_ERR_STATUS_IDX: begin
          rdata_q <= view_host_q ? eis_mirror(status_word) : status_word; // RQ22
        end
        eis_pkg::EIS_VIEW_SELECT_IDX: begin
          rdata_q <= {31'h0000_0000, view_host_q};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // registered copies for direct observation; one cycle behind the cells
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_out_q <= eis_pkg::EIS_ERR_STATUS_RST;
      any_q        <= 1'b0;
    end else begin
      status_out_q <= status_word;
      any_q        <= |flag_vec;
    end
  end

  assign reg_rdata            = rdata_q;
  assign error_status_word    = status_out_q;
  assign error_any            = any_q;
  assign primary_summary_flag = summary_q;

endmodule

//--- eis_error_status_checker.sv
// Purpose: concurrent checks on the error status register ports
// Assumes: single clock domain, async active-low reset
// Notes:   status word lags the cells by one clock, so events show 2 edges later
`timescale 1ns/10ps
module eis_error_status_checker (
  // clock and reset
  input wire logic                           clock,
  input wire logic                           reset_n,
  // register port
  input wire logic [eis_pkg::EIS_ADDR_W-1:0] reg_addr,
  input wire logic [eis_pkg::EIS_DATA_W-1:0] reg_wdata,
  input wire logic                           reg_wr,
  // events and status
  input wire eis_pkg::eis_host_evt_t         host_evt,
  input wire eis_pkg::eis_pci_evt_t          first_pci_evt,
  input wire eis_pkg::eis_pci_evt_t          second_pci_evt,
  input wire logic                           primary_status_any,
  input wire logic                           primary_summary_flag,
  input wire logic [31:0]                    error_status_word
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic quiet;
  assign quiet = (host_evt == '0) && (first_pci_evt == '0) && (second_pci_evt == '0);
  property p_sum_set; primary_status_any |=> primary_summary_flag; endproperty
  a_sum_set: assert property (p_sum_set) else $error("summary flag stayed low");
  property p_sum_clr; !primary_status_any |=> !primary_summary_flag; endproperty
  a_sum_clr: assert property (p_sum_clr) else $error("summary flag stayed high");
  property p_rsvd; (error_status_word & 32'h7101_0101) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_retry_p1; host_evt.retry_limit_first_pci |-> ##2 error_status_word[27]; endproperty
  a_retry_p1: assert property (p_retry_p1) else $error("bit 27 not set");
  property p_xerr_loop; host_evt.xfer_error_loop_dma |-> ##2 error_status_word[21]; endproperty
  a_xerr_loop: assert property (p_xerr_loop) else $error("bit 21 not set");
  // a clear write shows on the word two edges later, so look one write back
  property p_apar_hold;
    error_status_word[20] && !($past(reg_wr) && $past(reg_addr) == eis_pkg::EIS_ERR_STATUS_IDX)
      |=> error_status_word[20];
  endproperty
  a_apar_hold: assert property (p_apar_hold) else $error("bit 20 dropped");
  property p_p2_apar; second_pci_evt.addr_parity_error |-> ##2 error_status_word[12]; endproperty
  a_p2_apar: assert property (p_p2_apar) else $error("bit 12 not set");
  property p_p1_host; first_pci_evt.error_to_host |-> ##2 error_status_word[6]; endproperty
  a_p1_host: assert property (p_p1_host) else $error("bit 6 not set");
  property p_p1_loop; first_pci_evt.retry_loop_dma |-> ##2 error_status_word[1]; endproperty
  a_p1_loop: assert property (p_p1_loop) else $error("bit 1 not set");
  // all-ones write clears every field except the summary bit 31 in either view
  property p_clr_all;
    (reg_wr && reg_addr == eis_pkg::EIS_ERR_STATUS_IDX && (&reg_wdata) && quiet) ##1 quiet
      |=> error_status_word[30:0] == 31'h0000_0000;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("write of ones left a bit set");
  property p_rst_zero; $rose(reset_n) |-> error_status_word == 32'h0000_0000; endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("status not zero after reset");
endmodule

bind eis_error_status eis_error_status_checker i_chk (.clock(clock), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .host_evt(host_evt),
  .first_pci_evt(first_pci_evt), .second_pci_evt(second_pci_evt),
  .primary_status_any(primary_status_any), .primary_summary_flag(primary_summary_flag),
  .error_status_word(error_status_word));

//--- eis_error_status_tb.sv
// Purpose: self-checking bench for the error status register
// Assumes: dual pci build, pci view unless a test selects the mirror
// Notes:   events are one-cycle pulses; reads checked in the data cycle
`timescale 1ns/10ps
module eis_error_status_tb;
  localparam logic [3:0]  ST = eis_pkg::EIS_ERR_STATUS_IDX;
  localparam logic [31:0] ALL = 32'h0EFE_FEFE;
  localparam int          POS [24] = '{27, 26, 25, 23, 22, 21, 20, 19, 18, 17, 15, 14, 13,
                                       12, 11, 10, 9, 7, 6, 5, 4, 3, 2, 1};
  logic                   clock = 1'h0;
  logic                   reset_n = 1'h0;
  logic [3:0]             reg_addr = 4'h0;
  logic [31:0]            reg_wdata = 32'h0;
  logic                   reg_wr = 1'h0;
  logic                   reg_rd = 1'h0;
  logic [31:0]            reg_rdata;
  eis_pkg::eis_host_evt_t host_evt = '0;
  eis_pkg::eis_pci_evt_t  first_pci_evt = '0;
  eis_pkg::eis_pci_evt_t  second_pci_evt = '0;
  logic                   primary_status_any = 1'h0;
  logic                   primary_summary_flag;
  logic [31:0]            error_status_word;
  logic                   error_any;
  int                     bad_count = 0;
  int                     tests_run = 0;
  always #10 clock = ~clock;
  eis_error_status i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_evt(host_evt), .first_pci_evt(first_pci_evt), .second_pci_evt(second_pci_evt),
    .primary_status_any(primary_status_any), .primary_summary_flag(primary_summary_flag),
    .error_status_word(error_status_word), .error_any(error_any));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    @(negedge clock);
    check(what, exp, reg_rdata);
  endtask
  task automatic fire(input logic [23:0] v);
    @(posedge clock);
    {host_evt, second_pci_evt, first_pci_evt} <= v;
    @(posedge clock);
    {host_evt, second_pci_evt, first_pci_evt} <= '0;
  endtask
  task automatic t_events;
    logic [31:0] e;
    for (int j = 0; j < 24; j++) begin
      e = 32'h1 << POS[j];
      fire(24'h80_0000 >> j);
      rd("event bit", ST, e);
      check("word out", e, error_status_word);
      check("any out", 32'h1, {31'h0, error_any});
      wr(ST, ~e);
      rd("zero write kept", ST, e);
      wr(ST, e);
      rd("one write cleared", ST, 32'h0);
      check("any clear", 32'h0, {31'h0, error_any});
    end
    $display("test events done");
  endtask
  task automatic t_multi;
    fire(24'hFF_FFFF);
    rd("all events", ST, ALL);
    wr(ST, 32'h00F0_0F0F);
    rd("partial clear", ST, ALL & ~32'h00F0_0F0F);
    wr(4'hF, 32'hFFFF_FFFF);
    rd("unmapped read", 4'hF, 32'h0);
    rd("unmapped write ignored", ST, ALL & ~32'h00F0_0F0F);
    @(posedge clock);
    reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    rd("mid reset", ST, 32'h0);
    fire(24'hFF_FFFF);
    wr(ST, 32'hFFFF_FFFF);
    rd("ones clear all", ST, 32'h0);
    $display("test multi done");
  endtask
  task automatic t_summary;
    @(posedge clock);
    primary_status_any <= 1'h1;
    rd("summary set", ST, 32'h8000_0000);
    check("summary flag", 32'h1, {31'h0, primary_summary_flag});
    wr(ST, 32'hFFFF_FFFF);
    rd("summary read only", ST, 32'h8000_0000);
    @(posedge clock);
    primary_status_any <= 1'h0;
    rd("summary clear", ST, 32'h0);
    $display("test summary done");
  endtask
  task automatic t_mirror;
    wr(eis_pkg::EIS_VIEW_SELECT_IDX, 32'h1);
    rd("view read", eis_pkg::EIS_VIEW_SELECT_IDX, 32'h1);
    fire(24'h04_0000);
    rd("mirror read", ST, 32'h0000_0400);
    check("mirror word out", 32'h0020_0000, error_status_word);
    wr(ST, 32'h0000_0400);
    rd("mirror clear", ST, 32'h0);
    wr(eis_pkg::EIS_VIEW_SELECT_IDX, 32'h0);
    $display("test mirror done");
  endtask
  task automatic print_verdict;
    $display("checks run %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    rd("reset value", ST, 32'h0);
    check("reset word", 32'h0, error_status_word);
    t_events;
    t_multi;
    t_summary;
    t_mirror;
    print_verdict;
  end
  // run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    print_verdict;
  end
endmodule
